// *** urs_pkg.sv ***
package urs_pkg;

  // register port geometry: index times four is the byte address
  localparam int unsigned URS_ADDR_W = 5;
  localparam int unsigned URS_DATA_W = 8;
  localparam logic [2:0] URS_IDX_STATUS1 = 3'h0;
  localparam logic [2:0] URS_IDX_STATUS2 = 3'h1;
  localparam logic [2:0] URS_IDX_DATA = 3'h2;
  localparam logic [2:0] URS_IDX_CONTROL = 3'h3;
  localparam logic [2:0] URS_IDX_DIVISOR = 3'h4;

  // flag vector positions; bits 0..5 are also the receive_status_one layout
  localparam int unsigned URS_F_PARITY = 0;
  localparam int unsigned URS_F_FRAMING = 1;
  localparam int unsigned URS_F_NOISE = 2;
  localparam int unsigned URS_F_OVERRUN = 3;
  localparam int unsigned URS_F_IDLE = 4;
  localparam int unsigned URS_F_FULL = 5;
  localparam int unsigned URS_F_EDGE = 6;
  localparam int unsigned URS_F_BREAK = 7;
  localparam int unsigned URS_NUM_FLAGS = 8;
  localparam int unsigned URS_NUM_TWO_STEP = 6;

  // receive_status_two control bits
  localparam int unsigned URS_S2_INVERT = 4;
  localparam int unsigned URS_S2_IDLE_STBY = 3;
  localparam int unsigned URS_S2_LONG_BRK = 2;
  localparam int unsigned URS_S2_BRK_EN = 1;

  // serial_control_two bits
  localparam int unsigned URS_C_PARITY_EN = 0;
  localparam int unsigned URS_C_ODD = 1;
  localparam int unsigned URS_C_NINE = 2;
  localparam int unsigned URS_C_WAKE_ADDR = 3;
  localparam int unsigned URS_C_STANDBY = 4;
  localparam int unsigned URS_C_RX_BIT8 = 7;

  // divisor reset value and edge history preload value
  localparam logic [7:0] URS_DIV_RESET = 8'h35;
  localparam logic [2:0] URS_HIST_FULL = 3'h7;

  // sample phases of the 16x clock, numbered 1..16
  localparam logic [4:0] URS_RT_FIRST = 5'h01;
  localparam logic [4:0] URS_RT_VER1 = 5'h03;
  localparam logic [4:0] URS_RT_VER2 = 5'h05;
  localparam logic [4:0] URS_RT_VER3 = 5'h07;
  localparam logic [4:0] URS_RT_MID1 = 5'h08;
  localparam logic [4:0] URS_RT_MID2 = 5'h09;
  localparam logic [4:0] URS_RT_MID3 = 5'h0a;
  localparam logic [4:0] URS_RT_LAST = 5'h10;
  localparam logic [1:0] URS_VER_MIN_ZEROS = 2'h2;

  // data, frame and break lengths in bit times
  localparam logic [3:0] URS_DATA_BITS_8 = 4'h8;
  localparam logic [3:0] URS_DATA_BITS_9 = 4'h9;
  localparam logic [3:0] URS_FRAME_BITS_8 = 4'ha;
  localparam logic [3:0] URS_FRAME_BITS_9 = 4'hb;
  localparam logic [3:0] URS_LONG_BRK_8 = 4'hd;
  localparam logic [3:0] URS_LONG_BRK_9 = 4'he;

  typedef enum logic [1:0] {URS_SEARCH, URS_START, URS_DATA, URS_STOP} urs_state_e;

endpackage : urs_pkg

// *** urs_pin_sync.sv ***
`timescale 1ns/1ns
module urs_pin_sync #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // raw pin and filtered level
  input wire logic pinIn,
  output logic levelOut
);

  logic s1Q;
  logic s2Q;
  logic s3Q;
  logic levelQ;
  wire agree = (s2Q == s3Q);

  // three stages; the level only moves once stages two and three agree
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      s1Q <= IDLE_LEVEL;
      s2Q <= IDLE_LEVEL;
      s3Q <= IDLE_LEVEL;
      levelQ <= IDLE_LEVEL;
    end
    else
    begin
      s1Q <= pinIn;
      s2Q <= s1Q;
      s3Q <= s2Q;
      if (agree)
        levelQ <= s3Q;
    end
  end

  assign levelOut = levelQ;

endmodule : urs_pin_sync

// *** urs_sticky_flag.sv ***
`timescale 1ns/1ns
module urs_sticky_flag (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // hardware set, software clear
  input wire logic setIn,
  input wire logic clrIn,
  output logic flagOut
);

  logic flagQ;
  // a set in the clearing cycle wins so no event is lost
  wire flagD = setIn | (flagQ & ~clrIn);

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      flagQ <= 1'b0;
    else
      flagQ <= flagD;
  end

  assign flagOut = flagQ;

endmodule : urs_sticky_flag

// *** urs_receiver.sv ***
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ns
module urs_receiver
  import urs_pkg::*;
#(
  parameter logic [7:0] DIV_RESET = urs_pkg::URS_DIV_RESET
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // serial line
  input wire logic rxPin,
  // register port
  input wire logic [urs_pkg::URS_ADDR_W-1:0] regAddr,
  input wire logic [urs_pkg::URS_DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [urs_pkg::URS_DATA_W-1:0] regRdata,
  // line status
  output logic [3:0] breakBitTimes,
  output logic rxStandby
);

  import urs_pkg::*;

  logic [7:0] rdataQ;
  logic [7:0] divisorQ;
  logic [7:0] divCntQ;
  logic [3:0] s2CtlQ;
  logic [4:0] ctlQ;
  logic [7:0] dataQ;
  logic bit8Q;
  logic [3:0] brkLenQ;
  logic [URS_NUM_TWO_STEP-1:0] armQ;
  logic rxPrevQ;
  logic [7:0] idleCntQ;
  logic idleArmedQ;
  logic [URS_NUM_FLAGS-1:0] flags;
  logic [URS_NUM_FLAGS-1:0] flagSet;
  logic [URS_NUM_FLAGS-1:0] flagClr;
  logic pinLevel;
  urs_state_e stateQ;
  urs_state_e stateD;
  logic [4:0] rtQ;
  logic [4:0] rtD;
  logic [3:0] bitCntQ;
  logic [3:0] bitCntD;
  logic [8:0] shiftQ;
  logic [8:0] shiftD;
  logic s8Q;
  logic s8D;
  logic s9Q;
  logic s9D;
  logic noiseQ;
  logic noiseD;
  logic [1:0] verZerosQ;
  logic [1:0] verZerosD;
  logic [2:0] histQ;

  // register decode; addresses off the word grid hit nothing
  wire aligned = (regAddr[1:0] == 2'b00);
  wire [2:0] regIdx = regAddr[4:2];
  wire hitS1 = aligned && (regIdx == URS_IDX_STATUS1);
  wire hitS2 = aligned && (regIdx == URS_IDX_STATUS2);
  wire hitData = aligned && (regIdx == URS_IDX_DATA);
  wire hitCtl = aligned && (regIdx == URS_IDX_CONTROL);
  wire hitDiv = aligned && (regIdx == URS_IDX_DIVISOR);
  wire status1Read = regRead && hitS1;
  wire dataRead = regRead && hitData;
  wire s2Write = regWrite && hitS2;
  wire ctlWrite = regWrite && hitCtl;

  // control fields
  wire invert = s2CtlQ[URS_S2_INVERT-1];
  wire idleStbyEn = s2CtlQ[URS_S2_IDLE_STBY-1];
  wire longBrk = s2CtlQ[URS_S2_LONG_BRK-1];
  wire brkEn = s2CtlQ[URS_S2_BRK_EN-1];
  wire parityEn = ctlQ[URS_C_PARITY_EN];
  wire oddParity = ctlQ[URS_C_ODD];
  wire nineBit = ctlQ[URS_C_NINE];
  wire wakeAddr = ctlQ[URS_C_WAKE_ADDR];
  wire standbyQ = ctlQ[URS_C_STANDBY];

  // read mux; unmapped words read as zero
  wire [7:0] status1Val = {2'b00, flags[URS_NUM_TWO_STEP-1:0]};
  wire [7:0] status2Val = {flags[URS_F_BREAK], flags[URS_F_EDGE], 1'b0, s2CtlQ, 1'b0};
  wire [7:0] ctlVal = {bit8Q, 2'b00, ctlQ};
  wire [7:0] readVal = hitS1 ? status1Val :
                       hitS2 ? status2Val :
                       hitData ? dataQ :
                       hitCtl ? ctlVal :
                       hitDiv ? divisorQ : 8'h00;

  // 16x sample tick from the bus clock
  wire tick = (divCntQ == 8'h00);

  // pin path: filter, then polarity, then edge detection
  urs_pin_sync #(
    .IDLE_LEVEL(1'b1)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pinIn(rxPin),
    .levelOut(pinLevel)
  );
  wire sample = pinLevel ^ invert;
  wire pinEdge = rxPrevQ && !sample;

  // sampling decisions of the current tick
  wire inFrame = (stateQ != URS_SEARCH);
  wire edgeDet = tick && !sample && (histQ == URS_HIST_FULL);
  wire atVer = (rtQ == URS_RT_VER1) || (rtQ == URS_RT_VER2) || (rtQ == URS_RT_VER3);
  wire [1:0] verZerosNext = verZerosQ + {1'b0, !sample};
  wire startOk = (verZerosNext >= URS_VER_MIN_ZEROS);
  wire bitMaj = (s8Q & s9Q) | (s8Q & sample) | (s9Q & sample);
  wire bitNoisy = !((s8Q == s9Q) && (s9Q == sample));
  // an edge at or after the last vote sample closes the bit early
  wire bitEnd = (rtQ == URS_RT_LAST) || (edgeDet && (rtQ >= URS_RT_MID3));
  wire [3:0] dataBits = nineBit ? URS_DATA_BITS_9 : URS_DATA_BITS_8;
  wire [4:0] rtStep = rtQ + URS_RT_FIRST;
  // the edge sample itself is phase one, so the tick after it is phase two
  wire [4:0] rtAfterEdge = URS_RT_FIRST + 5'h01;

  // receive sequencer, advanced on sample ticks only
  always_comb
  begin
    stateD = stateQ;
    rtD = rtQ;
    bitCntD = bitCntQ;
    shiftD = shiftQ;
    s8D = s8Q;
    s9D = s9Q;
    noiseD = noiseQ;
    verZerosD = verZerosQ;
    if (tick)
    begin
      rtD = edgeDet ? rtAfterEdge : (bitEnd ? URS_RT_FIRST : rtStep);
      if (rtQ == URS_RT_MID1)
        s8D = sample;
      if (rtQ == URS_RT_MID2)
        s9D = sample;
      unique case (stateQ)
        URS_SEARCH:
        begin
          if (edgeDet)
          begin
            stateD = URS_START;
            verZerosD = 2'h0;
            noiseD = 1'b0;
          end
        end
        URS_START:
        begin
          if (edgeDet && !bitEnd)
          begin
            verZerosD = 2'h0;
            noiseD = 1'b0;
          end
          else if (atVer)
          begin
            verZerosD = verZerosNext;
            noiseD = noiseQ | sample;
            if ((rtQ == URS_RT_VER3) && !startOk)
              stateD = URS_SEARCH;
          end
          else if ((rtQ >= URS_RT_MID1) && (rtQ <= URS_RT_MID3))
            noiseD = noiseQ | sample;
          if (bitEnd)
          begin
            stateD = URS_DATA;
            bitCntD = 4'h0;
          end
        end
        URS_DATA:
        begin
          if (rtQ == URS_RT_MID3)
          begin
            shiftD = {bitMaj, shiftQ[8:1]};
            bitCntD = bitCntQ + 4'h1;
            noiseD = noiseQ | bitNoisy;
          end
          if (bitEnd && (bitCntD == dataBits))
            stateD = URS_STOP;
        end
        URS_STOP:
        begin
          if (rtQ == URS_RT_MID3)
            stateD = URS_SEARCH;
        end
      endcase
    end
  end

  // frame completion and its effects on the buffer
  wire frameEnd = tick && (stateQ == URS_STOP) && (rtQ == URS_RT_MID3);
  wire framing = !bitMaj;
  wire frameNoise = noiseQ | bitNoisy;
  wire [7:0] charData = nineBit ? shiftQ[7:0] : shiftQ[8:1];
  wire rxParity = nineBit ? (^shiftQ) : (^shiftQ[8:1]);
  wire parErr = parityEn && (rxParity != oddParity);
  wire isBreak = framing && (charData == 8'h00) && !(nineBit && shiftQ[8]);
  wire addrWake = standbyQ && wakeAddr && shiftQ[8] && !framing;
  wire quiet = standbyQ && !addrWake;
  wire brkChar = brkEn && isBreak;
  wire takeChar = frameEnd && !quiet && !brkChar;
  wire transfer = takeChar && !flags[URS_F_FRAMING] && !flags[URS_F_FULL];
  wire preload = frameEnd && framing && !isBreak;

  // idle detection: a whole frame time of ones after activity
  wire [7:0] idleTicks = {nineBit ? URS_FRAME_BITS_9 : URS_FRAME_BITS_8, 4'h0};
  wire idleEvent = tick && sample && idleArmedQ && (idleCntQ == (idleTicks - 8'h01));
  wire idleSetOk = !standbyQ || idleStbyEn;
  wire wakeIdle = idleEvent && standbyQ && !wakeAddr;

  // flag set terms
  assign flagSet[URS_F_FULL] = transfer;
  assign flagSet[URS_F_FRAMING] = transfer && framing;
  assign flagSet[URS_F_PARITY] = transfer && parErr;
  assign flagSet[URS_F_NOISE] = transfer && frameNoise;
  assign flagSet[URS_F_OVERRUN] = takeChar && !flags[URS_F_FRAMING] && flags[URS_F_FULL];
  assign flagSet[URS_F_IDLE] = idleEvent && idleSetOk;
  assign flagSet[URS_F_BREAK] = frameEnd && brkChar && !quiet;
  assign flagSet[URS_F_EDGE] = pinEdge;

  // two-step clears: status read arms the set bits, data read clears them
  assign flagClr[URS_NUM_TWO_STEP-1:0] = dataRead ? armQ : '0;
  assign flagClr[URS_F_EDGE] = s2Write && regWdata[URS_F_EDGE];
  assign flagClr[URS_F_BREAK] = s2Write && regWdata[URS_F_BREAK];

  genvar gi;
  generate
    for (gi = 0; gi < URS_NUM_FLAGS; gi++)
    begin : g_flag
      urs_sticky_flag u_flag (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .setIn(flagSet[gi]),
        .clrIn(flagClr[gi]),
        .flagOut(flags[gi])
      );
    end
  endgenerate

  // break length for the transmit side; framing checks never look at it
  wire [3:0] brkLenD = longBrk ? (nineBit ? URS_LONG_BRK_9 : URS_LONG_BRK_8) :
                       (nineBit ? URS_FRAME_BITS_9 : URS_FRAME_BITS_8);

  // sequencer state and edge history
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      stateQ <= URS_SEARCH;
      rtQ <= URS_RT_FIRST;
      bitCntQ <= 4'h0;
      shiftQ <= 9'h000;
      s8Q <= 1'b1;
      s9Q <= 1'b1;
      noiseQ <= 1'b0;
      verZerosQ <= 2'h0;
      histQ <= 3'h0;
    end
    else
    begin
      stateQ <= stateD;
      rtQ <= rtD;
      bitCntQ <= bitCntD;
      shiftQ <= shiftD;
      s8Q <= s8D;
      s9Q <= s9D;
      noiseQ <= noiseD;
      verZerosQ <= verZerosD;
      if (preload)
        histQ <= URS_HIST_FULL;
      else if (tick)
        histQ <= {histQ[1:0], sample};
    end
  end

  // receive buffer; an overrun leaves the held character in place
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      dataQ <= 8'h00;
      bit8Q <= 1'b0;
    end
    else if (transfer)
    begin
      dataQ <= charData;
      bit8Q <= nineBit && shiftQ[8];
    end
  end

  // software registers; a software write to standby beats a wakeup
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      s2CtlQ <= 4'h0;
      ctlQ <= 5'h00;
      divisorQ <= DIV_RESET;
      armQ <= '0;
    end
    else
    begin
      if (s2Write)
        s2CtlQ <= regWdata[URS_S2_INVERT:URS_S2_BRK_EN];
      if (ctlWrite)
        ctlQ <= regWdata[URS_C_STANDBY:0];
      else if (wakeIdle || (frameEnd && addrWake))
        ctlQ[URS_C_STANDBY] <= 1'b0;
      if (regWrite && hitDiv)
        divisorQ <= regWdata;
      if (status1Read)
        armQ <= flags[URS_NUM_TWO_STEP-1:0];
      else if (dataRead)
        armQ <= '0;
    end
  end

  // tick divider, pin edge memory, idle counter, outputs
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      divCntQ <= 8'h00;
      rxPrevQ <= 1'b1;
      idleCntQ <= 8'h00;
      idleArmedQ <= 1'b0;
      rdataQ <= 8'h00;
      brkLenQ <= URS_FRAME_BITS_8;
    end
    else
    begin
      divCntQ <= tick ? divisorQ : (divCntQ - 8'h01);
      rxPrevQ <= sample;
      if (tick)
        idleCntQ <= (!sample || idleEvent) ? 8'h00 : (idleCntQ + 8'h01);
      if (frameEnd || (ctlWrite && regWdata[URS_C_STANDBY]))
        idleArmedQ <= 1'b1;
      else if (idleEvent)
        idleArmedQ <= 1'b0;
      rdataQ <= regRead ? readVal : 8'h00;
      brkLenQ <= brkLenD;
    end
  end

  assign regRdata = rdataQ;
  assign breakBitTimes = brkLenQ;
  assign rxStandby = standbyQ;

  fe_with_full_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $rose(flags[URS_F_FRAMING]) |-> $rose(flags[URS_F_FULL]))
    else $error("framing flag rose without full flag");

  fe_clear_seq_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $fell(flags[URS_F_FRAMING]) |-> $past(dataRead) && $past(armQ[URS_F_FRAMING]))
    else $error("framing flag cleared without status then data read");

  pf_with_full_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (transfer && parErr) |=> flags[URS_F_PARITY] && flags[URS_F_FULL])
    else $error("parity error not flagged with full");

  pf_clear_seq_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $fell(flags[URS_F_PARITY]) |-> $past(dataRead))
    else $error("parity flag cleared without data read");

  brk_w1c_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (s2Write && regWdata[URS_F_BREAK] && !flagSet[URS_F_BREAK]) |=> !flags[URS_F_BREAK])
    else $error("break flag not cleared by writing one");

  pin_edge_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ($fell(pinLevel ^ invert) && $stable(invert)) |=> flags[URS_F_EDGE])
    else $error("active pin edge missed");

  idle_standby_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (standbyQ && !idleStbyEn && !flags[URS_F_IDLE]) |=> !flags[URS_F_IDLE])
    else $error("idle flag set in standby without enable");

  overrun_keep_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (frameEnd && flags[URS_F_FULL]) |=> $stable(dataQ))
    else $error("buffered character overwritten");

  phase_range_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    inFrame |-> (rtQ >= URS_RT_FIRST) && (rtQ <= URS_RT_LAST))
    else $error("sample phase out of range");

  start_vote_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (stateQ == URS_START) ##1 (stateQ == URS_DATA) |-> $past(verZerosQ, 1) >= URS_VER_MIN_ZEROS)
    else $error("start accepted with too few zeros");

  fe_block_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (frameEnd && flags[URS_F_FRAMING]) |=> $stable(dataQ) && !$rose(flags[URS_F_FULL]))
    else $error("character transferred while framing flag set");

  standby_quiet_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (frameEnd && quiet) |=> !$rose(flags[URS_F_FULL]) && !$rose(flags[URS_F_BREAK]))
    else $error("status flag set during standby");

endmodule : urs_receiver

// *** urs_tx_model.sv ***
`timescale 1ns/1ns
module urs_tx_model #(
  parameter int BIT_CLKS = 64
) (
  // clock
  input wire logic clk_sys,
  // serial line towards the receiver
  output logic serialOut
);
  // polarity the far side was told to use; idle is the inverse of a start bit
  logic invMode = 1'b0;

  initial serialOut = 1'b1;

  // switch polarity and park the line at the new idle level at once
  task automatic set_inv(input logic inv);
    invMode = inv;
    serialOut <= ~inv;
  endtask : set_inv

  // drive one level for a number of clocks
  task automatic hold(input logic lvl, input int clks);
    serialOut <= lvl;
    repeat (clks) @(posedge clk_sys);
  endtask : hold

  // one frame, start at bit 0, lsb first; glitchBit flips one sample slot mid-bit
  task automatic send(input logic [9:0] bits, input int glitchBit);
    for (int i = 0; i < 10; i++)
    begin
      for (int c = 0; c < BIT_CLKS; c++)
      begin
        serialOut <= bits[i] ^ invMode ^ (i == glitchBit && c >= 34 && c < 38);
        @(posedge clk_sys);
      end
    end
    // short idle only, so status reads happen before an idle line is seen
    hold(~invMode, BIT_CLKS);
  endtask : send
endmodule : urs_tx_model

// *** tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  import urs_pkg::*;

  localparam logic [4:0] A_S1 = {URS_IDX_STATUS1, 2'b00};
  localparam logic [4:0] A_S2 = {URS_IDX_STATUS2, 2'b00};
  localparam logic [4:0] A_DATA = {URS_IDX_DATA, 2'b00};
  localparam logic [4:0] A_CTRL = {URS_IDX_CONTROL, 2'b00};
  localparam logic [4:0] A_DIV = {URS_IDX_DIVISOR, 2'b00};
  localparam int GAP = 768;

  logic clk_sys;
  logic resetn;
  logic [URS_ADDR_W-1:0] regAddr;
  logic [URS_DATA_W-1:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [URS_DATA_W-1:0] regRdata;
  logic [3:0] breakBitTimes;
  logic rxStandby;
  logic rxLine;
  int fail_count = 0;
  int check_count = 0;

  urs_receiver u_urs_receiver (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .rxPin(rxLine),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdata(regRdata),
    .breakBitTimes(breakBitTimes),
    .rxStandby(rxStandby)
  );

  // 64 clocks per bit matches a divisor of 3
  urs_tx_model #(.BIT_CLKS(64)) u_urs_tx_model (
    .clk_sys(clk_sys),
    .serialOut(rxLine)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // bus tasks are entered just after a rising edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    // spare edge so a following write never assigns the strobe twice at once
    @(posedge clk_sys);
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 d = regRdata;
    @(posedge clk_sys);
  endtask : rd

  task automatic rc(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rc

  // idle flag depends on line gaps, so it is masked out here
  task automatic rs1(input logic [7:0] exp);
    logic [7:0] d;
    rd(A_S1, d);
    chk(d & 8'hef, exp);
  endtask : rs1

  function automatic logic [9:0] fr(input logic [7:0] d, input logic stop);
    return {stop, d, 1'b0};
  endfunction : fr

  task automatic t_reset();
    rs1(8'h00);
    rc(A_S2, 8'h00);
    rc(A_CTRL, 8'h00);
    rc(A_DIV, 8'h35);
    rc(5'h14, 8'h00);
    rc(5'h11, 8'h00);
    wr(A_S1, 8'hff);
    rs1(8'h00);
    chk({4'h0, breakBitTimes}, 8'h0a);
    wr(A_DIV, 8'h03);
    rc(A_DIV, 8'h03);
  endtask : t_reset

  task automatic t_plain();
    wr(A_S2, 8'h40);
    u_urs_tx_model.send(fr(8'ha5, 1'b1), 99);
    rc(A_S2, 8'h40);
    wr(A_S2, 8'h40);
    rc(A_S2, 8'h00);
    rc(A_DATA, 8'ha5);
    rs1(8'h20);
    rc(A_DATA, 8'ha5);
    rs1(8'h00);
  endtask : t_plain

  // second frame arrives while the framing flag is still up
  task automatic t_framing();
    u_urs_tx_model.send(fr(8'h55, 1'b0), 99);
    rs1(8'h22);
    u_urs_tx_model.hold(1'b1, GAP);
    u_urs_tx_model.send(fr(8'h3c, 1'b1), 99);
    rs1(8'h22);
    rc(A_DATA, 8'h55);
    rs1(8'h00);
  endtask : t_framing

  // 8'h83: seven data bits with two ones, parity bit 1
  task automatic t_parity();
    logic [7:0] d;
    wr(A_CTRL, 8'h01);
    u_urs_tx_model.send(fr(8'h83, 1'b1), 99);
    rs1(8'h21);
    rd(A_DATA, d);
    rs1(8'h00);
    wr(A_CTRL, 8'h03);
    u_urs_tx_model.send(fr(8'h83, 1'b1), 99);
    rs1(8'h20);
    rd(A_DATA, d);
    wr(A_CTRL, 8'h00);
  endtask : t_parity

  // nine-bit frame: the model's trailing idle doubles as the stop bit
  task automatic t_nine();
    wr(A_CTRL, 8'h04);
    u_urs_tx_model.send(fr(8'hc3, 1'b1), 99);
    rs1(8'h20);
    rc(A_CTRL, 8'h84);
    rc(A_DATA, 8'hc3);
    rs1(8'h00);
    wr(A_CTRL, 8'h00);
  endtask : t_nine

  task automatic t_overrun();
    u_urs_tx_model.send(fr(8'h11, 1'b1), 99);
    u_urs_tx_model.send(fr(8'h22, 1'b1), 99);
    rs1(8'h28);
    rc(A_DATA, 8'h11);
    rs1(8'h00);
  endtask : t_overrun

  // a one-sample high blip inside a zero bit, then a too-short low pulse
  task automatic t_noise();
    u_urs_tx_model.send(fr(8'h00, 1'b1), 4);
    rs1(8'h24);
    rc(A_DATA, 8'h00);
    rs1(8'h00);
    u_urs_tx_model.hold(1'b0, 8);
    u_urs_tx_model.hold(1'b1, GAP);
    rs1(8'h00);
  endtask : t_noise

  task automatic t_invert();
    u_urs_tx_model.set_inv(1'b1);
    wr(A_S2, 8'h10);
    u_urs_tx_model.hold(1'b0, GAP);
    wr(A_S2, 8'h50);
    rs1(8'h00);
    u_urs_tx_model.send(fr(8'h5a, 1'b1), 99);
    rc(A_S2, 8'h50);
    rs1(8'h20);
    rc(A_DATA, 8'h5a);
    u_urs_tx_model.set_inv(1'b0);
    wr(A_S2, 8'h40);
    u_urs_tx_model.hold(1'b1, GAP);
    wr(A_S2, 8'h40);
    rs1(8'h00);
  endtask : t_invert

  task automatic t_break();
    wr(A_S2, 8'h42);
    u_urs_tx_model.send(fr(8'h00, 1'b0), 99);
    rc(A_S2, 8'hc2);
    rs1(8'h00);
    wr(A_S2, 8'hc2);
    rc(A_S2, 8'h02);
    wr(A_S2, 8'h00);
    u_urs_tx_model.hold(1'b1, GAP);
  endtask : t_break

  // address-mark wakeup: a frame with msb 0 is ignored, msb 1 wakes
  task automatic t_standby();
    wr(A_CTRL, 8'h18);
    #1 chk({7'h0, rxStandby}, 8'h01);
    @(posedge clk_sys);
    u_urs_tx_model.send(fr(8'h05, 1'b1), 99);
    rs1(8'h00);
    #1 chk({7'h0, rxStandby}, 8'h01);
    @(posedge clk_sys);
    u_urs_tx_model.send(fr(8'h85, 1'b1), 99);
    #1 chk({7'h0, rxStandby}, 8'h00);
    @(posedge clk_sys);
    rs1(8'h20);
    rc(A_DATA, 8'h85);
    rc(A_CTRL, 8'h08);
    wr(A_CTRL, 8'h00);
  endtask : t_standby

  // idle wakeup: the idle flag in standby follows the idle-in-standby enable
  task automatic t_idle();
    logic [7:0] d;
    u_urs_tx_model.hold(1'b1, 1100);
    rd(A_S1, d);
    rd(A_DATA, d);
    rc(A_S1, 8'h00);
    wr(A_CTRL, 8'h10);
    u_urs_tx_model.hold(1'b1, 1100);
    #1 chk({7'h0, rxStandby}, 8'h00);
    @(posedge clk_sys);
    rc(A_S1, 8'h00);
    wr(A_S2, 8'h08);
    wr(A_CTRL, 8'h10);
    u_urs_tx_model.hold(1'b1, 1100);
    #1 chk({7'h0, rxStandby}, 8'h00);
    @(posedge clk_sys);
    rc(A_S1, 8'h10);
    rd(A_DATA, d);
    rc(A_S1, 8'h00);
    wr(A_S2, 8'h00);
  endtask : t_idle

  // output lags the control write by one cycle
  task automatic bl(input logic [7:0] s2, input logic [7:0] c, input logic [7:0] exp);
    wr(A_S2, s2);
    wr(A_CTRL, c);
    @(posedge clk_sys);
    #1 chk({4'h0, breakBitTimes}, exp);
    @(posedge clk_sys);
  endtask : bl

  // hang guard
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    print_verdict();
  end

  initial
  begin
    resetn = 1'b0;
    regAddr = '0;
    regWdata = '0;
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    u_urs_tx_model.hold(1'b1, 64);
    t_plain();
    t_framing();
    t_parity();
    t_nine();
    t_overrun();
    t_noise();
    t_invert();
    t_break();
    t_standby();
    t_idle();
    bl(8'h04, 8'h00, 8'h0d);
    bl(8'h04, 8'h04, 8'h0e);
    bl(8'h00, 8'h04, 8'h0b);
    bl(8'h00, 8'h00, 8'h0a);
    print_verdict();
  end
endmodule : tb_top
